// ===== rtl/sba_pkg.sv
package sba_pkg;

	localparam int AD_W = 64;
	localparam int CMD_W = 9;
	localparam int IP_W = 8;

	// command bus layout
	localparam int CMD_DATA_BIT = 8;
	localparam int CMD_LAST_BIT = 7;
	localparam int CMD_ERR_BIT = 5;
	localparam int CMD_BLK_BIT = 4;
	localparam int CMD_TYPE_HI = 7;
	localparam int CMD_TYPE_LO = 5;
	localparam logic [2:0] CMD_TYPE_READ = 3'h0;
	localparam logic [2:0] CMD_TYPE_WRITE = 3'h2;
	localparam logic [2:0] CMD_TYPE_NULL = 3'h3;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h3;
	localparam logic [2:0] SIZE_DWORD = 3'h7;
	localparam logic [2:0] BLK_WORDS = 3'h4;

	// timing, in pipeline cycles; pipeline clock equals the input clock here
	localparam int PCYC_PER_CLK = 1;
	localparam int IN_SYNC_STAGES = 2;
	localparam int RLS_MIN_PCYC = 4;
	localparam int RLS_MAX_CAT1 = 6;
	localparam int RLS_MAX_CAT2 = 24;
	localparam logic [4:0] RLS_WAIT_CYC =
		5'(RLS_MIN_PCYC / PCYC_PER_CLK - IN_SYNC_STAGES - 1);
	localparam int WR_PERIOD_COMPAT = 4;
	localparam int WR_PERIOD_FAST = 2;
	localparam logic [2:0] WR_GAP_COMPAT = 3'(WR_PERIOD_COMPAT - 2);
	localparam logic [2:0] WR_GAP_FAST = 3'(WR_PERIOD_FAST - 2);

	// write modes
	localparam logic [1:0] WMODE_COMPAT = 2'h0;

	// register map, byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA_LO = 8'h08;
	localparam logic [7:0] OFS_WDATA_HI = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_RDATA_LO = 8'h18;
	localparam logic [7:0] OFS_RDATA_HI = 8'h1C;
	localparam logic [7:0] OFS_IP = 8'h20;
	localparam int CTRL_REV_BIT = 2;
	localparam int CMDR_WR_BIT = 0;
	localparam int CMDR_BLK_BIT = 1;
	localparam int CMDR_SIZE_LO = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RDPEND_BIT = 1;
	localparam int STAT_SLAVE_BIT = 2;
	localparam int STAT_ERR_BIT = 3;
	localparam int STAT_ENDIAN_BIT = 4;

	typedef enum logic [2:0] {
		S_MASTER = 3'b000,
		S_WDATA  = 3'b001,
		S_WGAP   = 3'b010,
		S_SLAVE  = 3'b011,
		S_EXT_WR = 3'b100,
		S_EXT_RD = 3'b101
	} sba_state_t;

	typedef struct packed {
		logic [AD_W-1:0]  ad;
		logic [CMD_W-1:0] cmd;
		logic             agent_drive_strobe_n;
		logic             read_accept_ready_n;
		logic             write_accept_ready_n;
		logic             bus_request_n;
		logic             endian_strap;
	} sba_sys_in_t;

	typedef struct packed {
		logic [AD_W-1:0]  ad;
		logic             ad_oe;
		logic [CMD_W-1:0] cmd;
		logic             cmd_oe;
		logic             proc_drive_strobe_n;
		logic             release_n;
	} sba_sys_out_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} sba_ahb_req_t;

endpackage : sba_pkg

// ===== rtl/sba_arbiter.sv
module sba_arbiter
	import sba_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	// register bus
	input  wire sba_ahb_req_t ahb_i,
	output logic              hreadyout_o,
	output logic              hresp_o,
	output logic [31:0]       hrdata_o,
	// system interface pins
	input  wire sba_sys_in_t  sys_i,
	output sba_sys_out_t      sys_o
);

	typedef struct packed {
		sba_state_t       st;
		logic [1:0]       wmode;
		logic             rev_end;
		logic             endian;
		logic [1:0]       strap_cnt;
		logic [31:0]      addr;
		logic [AD_W-1:0]  wdata;
		logic             cmd_wr;
		logic             cmd_blk;
		logic [2:0]       cmd_size;
		logic             cmd_pend;
		logic             rd_pend;
		logic [2:0]       rd_left;
		logic [AD_W-1:0]  rdata;
		logic             bus_err;
		logic [IP_W-1:0]  ip;
		logic [4:0]       lat_cnt;
		logic [2:0]       gap_cnt;
		sba_sys_in_t      in_m;
		sba_sys_in_t      in_s;
		sba_sys_out_t     out;
		logic             dph_wr;
		logic [7:0]       dph_addr;
		logic [31:0]      hrdata;
		logic             hready;
	} sba_regs_t;

	sba_regs_t q;
	sba_regs_t d;

	function automatic logic [31:0] align_addr(input logic [31:0] a, input logic blk,
			input logic [2:0] size);
		logic [31:0] r;
		r = a;
		if (blk || size == SIZE_DWORD) begin
			r[2:0] = 3'h0;
		end else if (size == SIZE_WORD) begin
			r[1:0] = 2'h0;
		end else if (size == SIZE_HALF) begin
			r[0] = 1'b0;
		end
		return r;
	endfunction : align_addr

	function automatic logic [31:0] swap32(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : swap32

	logic             ahb_sel;
	logic             err_set;
	logic             err_clr;
	logic             rd_ok;
	logic             wr_ok;
	logic             ready_ok;
	logic             breq;
	logic             agent_valid;
	logic [31:0]      rd_val;
	logic [AD_W-1:0]  rview;

	always_comb begin
		d = q;
		err_set = 1'b0;
		err_clr = 1'b0;
		rd_val = 32'h0000_0000;
		// input pins pass two flops before use
		d.in_m = sys_i;
		d.in_s = q.in_m;
		breq = ~q.in_s.bus_request_n;
		agent_valid = ~q.in_s.agent_drive_strobe_n;
		rd_ok = ~q.in_s.read_accept_ready_n;
		wr_ok = ~q.in_s.write_accept_ready_n;
		ready_ok = q.cmd_wr ? wr_ok : rd_ok;
		// reverse endian only changes what software sees, never pin byte order
		rview = q.rev_end ? {swap32(q.rdata[31:0]), swap32(q.rdata[63:32])} : q.rdata;
		d.out.proc_drive_strobe_n = 1'b1;
		d.out.release_n = 1'b1;

		// endian strap is caught once after reset and then held
		if (q.strap_cnt != 2'h3) begin
			d.strap_cnt = q.strap_cnt + 2'h1;
			if (q.strap_cnt == 2'h2) begin
				d.endian = q.in_s.endian_strap;
			end
		end

		case (q.st)
			S_MASTER: begin
				d.out.ad_oe = 1'b1;
				d.out.cmd_oe = 1'b1;
				d.lat_cnt = breq ? ((q.lat_cnt == 5'h1F) ? q.lat_cnt : q.lat_cnt + 5'h1)
					: 5'h0;
				if (q.rd_pend) begin
					// back in master after an interleaved request: hand back again
					d.out.release_n = 1'b0;
					d.out.ad_oe = 1'b0;
					d.out.cmd_oe = 1'b0;
					d.st = S_SLAVE;
				end else if (q.cmd_pend && ready_ok) begin
					d.cmd_pend = 1'b0;
					d.out.ad = {32'h0000_0000, align_addr(q.addr, q.cmd_blk, q.cmd_size)};
					d.out.cmd = '0;
					d.out.cmd[CMD_TYPE_HI:CMD_TYPE_LO] = q.cmd_wr ? CMD_TYPE_WRITE
						: CMD_TYPE_READ;
					d.out.cmd[CMD_BLK_BIT] = q.cmd_blk;
					d.out.cmd[2:0] = q.cmd_size;
					d.out.proc_drive_strobe_n = 1'b0;
					if (q.cmd_wr) begin
						d.st = S_WDATA;
					end else begin
						d.rd_pend = 1'b1;
						d.rd_left = q.cmd_blk ? BLK_WORDS : 3'h1;
						d.out.release_n = 1'b0;
						d.st = S_SLAVE;
					end
				end else if (breq && q.lat_cnt >= RLS_WAIT_CYC) begin
					d.out.release_n = 1'b0;
					d.out.ad_oe = 1'b0;
					d.out.cmd_oe = 1'b0;
					d.lat_cnt = 5'h0;
					d.st = S_SLAVE;
				end
			end
			S_WDATA: begin
				d.out.ad = q.wdata;
				d.out.cmd = '0;
				d.out.cmd[CMD_DATA_BIT] = 1'b1;
				d.out.cmd[CMD_LAST_BIT] = 1'b1;
				d.out.proc_drive_strobe_n = 1'b0;
				// compat mode leaves two idle cycles; fast modes none
				d.gap_cnt = (q.wmode == WMODE_COMPAT) ? WR_GAP_COMPAT : WR_GAP_FAST;
				d.st = (d.gap_cnt == 3'h0) ? S_MASTER : S_WGAP;
				d.lat_cnt = breq ? q.lat_cnt + 5'h1 : 5'h0;
			end
			S_WGAP: begin
				// request still in progress, so no release here
				d.gap_cnt = q.gap_cnt - 3'h1;
				d.lat_cnt = breq ? q.lat_cnt + 5'h1 : 5'h0;
				if (q.gap_cnt == 3'h1) begin
					d.st = S_MASTER;
				end
			end
			S_SLAVE: begin
				d.out.ad_oe = 1'b0;
				d.out.cmd_oe = 1'b0;
				d.lat_cnt = 5'h0;
				if (agent_valid) begin
					if (q.in_s.cmd[CMD_DATA_BIT]) begin
						if (q.rd_pend) begin
							d.rdata = q.in_s.ad;
							if (q.in_s.cmd[CMD_ERR_BIT]) begin
								err_set = 1'b1;
							end
							d.rd_left = q.rd_left - 3'h1;
							if (q.rd_left == 3'h1) begin
								d.rd_pend = 1'b0;
								d.st = S_MASTER;
								d.out.ad_oe = 1'b1;
								d.out.cmd_oe = 1'b1;
							end
						end
					end else begin
						// split read: an unrelated request may come first
						case (q.in_s.cmd[CMD_TYPE_HI:CMD_TYPE_LO])
							CMD_TYPE_READ: begin
								d.st = S_EXT_RD;
							end
							CMD_TYPE_WRITE: begin
								d.st = S_EXT_WR;
							end
							default: begin
								d.st = S_MASTER;
								d.out.ad_oe = 1'b1;
								d.out.cmd_oe = 1'b1;
							end
						endcase
					end
				end
			end
			S_EXT_WR: begin
				d.out.ad_oe = 1'b0;
				d.out.cmd_oe = 1'b0;
				if (agent_valid && q.in_s.cmd[CMD_DATA_BIT]) begin
					d.ip = q.in_s.ad[IP_W-1:0];
					d.st = S_MASTER;
					d.out.ad_oe = 1'b1;
					d.out.cmd_oe = 1'b1;
				end
			end
			S_EXT_RD: begin
				// nothing inside is readable: answer with flagged data
				d.out.ad = '0;
				d.out.cmd = '0;
				d.out.cmd[CMD_DATA_BIT] = 1'b1;
				d.out.cmd[CMD_LAST_BIT] = 1'b1;
				d.out.cmd[CMD_ERR_BIT] = 1'b1;
				d.out.ad_oe = 1'b1;
				d.out.cmd_oe = 1'b1;
				d.out.proc_drive_strobe_n = 1'b0;
				err_set = 1'b1;
				d.st = S_MASTER;
			end
			default: begin
				d.st = S_MASTER;
			end
		endcase

		// register bus data phase; writes to the request registers are
		// ignored while a request is queued, so the queued one stays intact
		if (q.dph_wr) begin
			case (q.dph_addr)
				OFS_CTRL: begin
					d.wmode = ahb_i.hwdata[1:0];
					d.rev_end = ahb_i.hwdata[CTRL_REV_BIT];
				end
				OFS_ADDR: begin
					if (!q.cmd_pend) begin
						d.addr = ahb_i.hwdata;
					end
				end
				OFS_WDATA_LO: begin
					if (!q.cmd_pend) begin
						d.wdata[31:0] = ahb_i.hwdata;
					end
				end
				OFS_WDATA_HI: begin
					if (!q.cmd_pend) begin
						d.wdata[63:32] = ahb_i.hwdata;
					end
				end
				OFS_CMD: begin
					if (!q.cmd_pend) begin
						d.cmd_wr = ahb_i.hwdata[CMDR_WR_BIT];
						d.cmd_blk = ahb_i.hwdata[CMDR_BLK_BIT];
						d.cmd_size = ahb_i.hwdata[CMDR_SIZE_LO+2:CMDR_SIZE_LO];
						d.cmd_pend = 1'b1;
					end
				end
				OFS_STATUS: begin
					err_clr = ahb_i.hwdata[STAT_ERR_BIT];
				end
				default: begin
				end
			endcase
		end
		// a new error in the clearing cycle survives
		d.bus_err = (q.bus_err & ~err_clr) | err_set;

		// register bus address phase; read data is ready for the data phase
		ahb_sel = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
		d.dph_wr = ahb_sel & ahb_i.hwrite;
		d.dph_addr = ahb_i.haddr[7:0];
		case (ahb_i.haddr[7:0])
			OFS_CTRL:     rd_val = {29'h0, q.rev_end, q.wmode};
			OFS_ADDR:     rd_val = q.addr;
			OFS_WDATA_LO: rd_val = q.wdata[31:0];
			OFS_WDATA_HI: rd_val = q.wdata[63:32];
			OFS_CMD:      rd_val = {27'h0, q.cmd_size, q.cmd_blk, q.cmd_wr};
			OFS_STATUS: begin
				rd_val[STAT_BUSY_BIT] = q.cmd_pend | q.rd_pend | (q.st != S_MASTER);
				rd_val[STAT_RDPEND_BIT] = q.rd_pend;
				rd_val[STAT_SLAVE_BIT] = ~q.out.ad_oe;
				rd_val[STAT_ERR_BIT] = q.bus_err;
				rd_val[STAT_ENDIAN_BIT] = q.endian;
			end
			OFS_RDATA_LO: rd_val = rview[31:0];
			OFS_RDATA_HI: rd_val = rview[63:32];
			OFS_IP:       rd_val = {{(32-IP_W){1'b0}}, q.ip};
			default:      rd_val = 32'h0000_0000;
		endcase
		if (ahb_sel && !ahb_i.hwrite) begin
			d.hrdata = rd_val;
		end
		d.hready = 1'b1;

		if (rst_i) begin
			d = '0;
			d.st = S_MASTER;
			d.in_m.agent_drive_strobe_n = 1'b1;
			d.in_m.read_accept_ready_n = 1'b1;
			d.in_m.write_accept_ready_n = 1'b1;
			d.in_m.bus_request_n = 1'b1;
			d.in_s = d.in_m;
			d.out.ad_oe = 1'b1;
			d.out.cmd_oe = 1'b1;
			d.out.proc_drive_strobe_n = 1'b1;
			d.out.release_n = 1'b1;
			d.hready = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		q <= d;
	end

	assign sys_o = q.out;
	assign hreadyout_o = q.hready;
	assign hresp_o = 1'b0;
	assign hrdata_o = q.hrdata;

endmodule : sba_arbiter

// ===== dv/sba_arbiter_chk.sv
module sba_chk
	import sba_pkg::*;
(
	// watched ports
	input wire logic         core_clk_i,
	input wire logic         rst_i,
	input wire sba_ahb_req_t ahb_i,
	input wire logic         hreadyout_o,
	input wire logic         hresp_o,
	input wire logic [31:0]  hrdata_o,
	input wire sba_sys_in_t  sys_i,
	input wire sba_sys_out_t sys_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	logic adr;
	logic [2:0] sz;
	assign adr = !sys_o.proc_drive_strobe_n && sys_o.ad_oe && !sys_o.cmd[CMD_DATA_BIT];
	assign sz = sys_o.cmd[4] ? SIZE_DWORD : sys_o.cmd[2:0];
	sequence s_wr_adr;
		adr && sys_o.cmd[7:5] == CMD_TYPE_WRITE;
	endsequence
	sequence s_wr_dat;
		!sys_o.proc_drive_strobe_n && sys_o.cmd[CMD_DATA_BIT] && sys_o.cmd[CMD_LAST_BIT];
	endsequence
	// agent read seen at the pins; the answer lags by the input sync
	sequence s_ext_rd;
		!sys_i.agent_drive_strobe_n && !sys_i.cmd[CMD_DATA_BIT] && sys_i.cmd[7:5] == 3'h0
			&& !sys_o.ad_oe;
	endsequence
	AST_RD_RLS: assert property (adr && sys_o.cmd[7:5] == CMD_TYPE_READ |-> !sys_o.release_n)
		else $error("read issued without release");
	AST_RLS: assert property (!sys_o.release_n |=> sys_o.release_n && !sys_o.ad_oe)
		else $error("release not a one cycle handover");
	AST_HI: assert property (adr |-> sys_o.ad[63:32] == 32'h0)
		else $error("upper bus bits used in address");
	AST_AL_H: assert property (adr && sz == SIZE_HALF |-> !sys_o.ad[0])
		else $error("half address misaligned");
	AST_AL_W: assert property (adr && sz == SIZE_WORD |-> sys_o.ad[1:0] == 2'h0)
		else $error("word address misaligned");
	AST_AL_D: assert property (adr && sz == SIZE_DWORD |-> sys_o.ad[2:0] == 3'h0)
		else $error("dword address misaligned");
	AST_WR: assert property (s_wr_adr |=> s_wr_dat)
		else $error("write data cycle missing");
	AST_DRV: assert property (!sys_o.proc_drive_strobe_n |-> sys_o.ad_oe && sys_o.cmd_oe)
		else $error("strobe without driving");
	AST_EXT_RD: assert property (s_ext_rd |-> ##[1:10] (!sys_o.proc_drive_strobe_n
		&& sys_o.cmd[CMD_DATA_BIT] && sys_o.cmd[CMD_ERR_BIT]))
		else $error("agent read not answered with error word");
endmodule : sba_chk

bind sba_arbiter sba_chk u_chk (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .ahb_i(ahb_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .hrdata_o(hrdata_o), .sys_i(sys_i), .sys_o(sys_o)
);

// ===== dv/sba_agent_model.sv
module sba_agent_model
	import sba_pkg::*;
(
	// clock and pins
	input  wire logic         core_clk_i,
	input  wire sba_sys_out_t sys_o_i,
	output sba_sys_in_t       sys_i_o,
	// bench commands
	input  wire logic         ext_go_i,
	input  wire logic [2:0]   ext_type_i,
	input  wire logic         rsp_err_i,
	input  wire logic [63:0]  data_i,
	output logic              busy_o,
	output int                lat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	logic rd_seen;
	logic rd_addr;
	// a processor read address cycle as it stood before the last edge
	assign rd_addr = sys_o_i.ad_oe && !sys_o_i.proc_drive_strobe_n
		&& !sys_o_i.cmd[CMD_DATA_BIT] && sys_o_i.cmd[7:5] == CMD_TYPE_READ;
	// released lines show the inverse so a stale value never looks valid
	task automatic drive(input logic [63:0] d, input logic [8:0] c);
		@(posedge core_clk_i);
		sys_i_o.ad <= d;
		sys_i_o.cmd <= c;
		sys_i_o.agent_drive_strobe_n <= 1'b0;
		@(posedge core_clk_i);
		sys_i_o.ad <= ~d;
		sys_i_o.cmd <= ~c;
		sys_i_o.agent_drive_strobe_n <= 1'b1;
	endtask : drive
	initial begin
		sys_i_o = '0;
		sys_i_o.agent_drive_strobe_n = 1'b1;
		sys_i_o.bus_request_n = 1'b1;
		sys_i_o.endian_strap = 1'b1;
		busy_o = 1'b0;
		lat_o = 0;
		rd_seen = 1'b0;
		forever begin
			@(posedge core_clk_i);
			if (ext_go_i) begin
				busy_o <= 1'b1;
				sys_i_o.bus_request_n <= 1'b0;
				for (n = 1; n < 40 && sys_o_i.release_n; n++) begin
					@(posedge core_clk_i);
				end
				lat_o <= n - 2;
				// a read issued with this release is answered after our request
				rd_seen = rd_addr;
				sys_i_o.bus_request_n <= 1'b1;
				drive(64'h0, {1'b0, ext_type_i, 5'h0});
				if (ext_type_i == CMD_TYPE_WRITE) begin
					drive(data_i, 9'h180);
				end
				busy_o <= 1'b0;
			end else if (rd_seen || rd_addr) begin
				rd_seen = 1'b0;
				repeat (2) @(posedge core_clk_i);
				drive(data_i, {3'b110, rsp_err_i, 5'h0});
			end
		end
	end
endmodule : sba_agent_model

// ===== dv/system_bus_request_arbitration_test.sv
module system_bus_request_arbitration_test
	import sba_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, e) begin \
	total_checks++; \
	if ((a) !== (e)) begin \
		fail_count++; \
		$display("ERROR %0t got %h exp %h", $time, a, e); \
	end \
end
	logic         core_clk_i, rst_i, ext_go, rsp_err, busy, hreadyout_o, hresp_o;
	logic [2:0]   ext_type;
	logic [31:0]  hrdata_o, r;
	logic [63:0]  rdat;
	int           fail_count, total_checks, lat, i;
	sba_ahb_req_t ahb_q, ahb_w;
	sba_sys_in_t  sys_i;
	sba_sys_out_t sys_o, s;
	logic [2:0]   sz [3] = '{SIZE_HALF, SIZE_WORD, SIZE_DWORD};
	logic [31:0]  wa [3] = '{32'h103, 32'h107, 32'h10F};
	logic [31:0]  ea [3] = '{32'h102, 32'h104, 32'h108};
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	always_comb begin
		ahb_w = ahb_q;
		ahb_w.hready = hreadyout_o;
	end
	sba_arbiter uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ahb_i(ahb_w),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
		.sys_i(sys_i), .sys_o(sys_o));
	sba_agent_model agent (.core_clk_i(core_clk_i), .sys_o_i(sys_o), .sys_i_o(sys_i),
		.ext_go_i(ext_go), .ext_type_i(ext_type), .rsp_err_i(rsp_err), .data_i(rdat),
		.busy_o(busy), .lat_o(lat));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	task automatic bound(input int n);
		if (n >= 60) begin
			fail_count++;
			give_verdict();
		end
	endtask : bound
	task automatic hwait();
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge core_clk_i);
			if (hreadyout_o === 1'b1) break;
		end
		bound(n);
	endtask : hwait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		ahb_q.hsel <= 1'b1;
		ahb_q.htrans <= 2'h2;
		ahb_q.haddr <= {24'h0, a};
		ahb_q.hwrite <= w;
		ahb_q.hsize <= 3'h2;
		hwait();
		ahb_q.htrans <= 2'h0;
		ahb_q.hwdata <= d;
		hwait();
		r = hrdata_o;
	endtask : bus
	task automatic wstb();
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge core_clk_i);
			if (sys_o.proc_drive_strobe_n === 1'b0) break;
		end
		bound(n);
		s = sys_o;
	endtask : wstb
	task automatic poll(input int b, input logic v);
		int n;
		for (n = 0; n < 60; n++) begin
			bus(1'b0, OFS_STATUS, 32'h0);
			if (r[b] === v) break;
		end
		bound(n);
	endtask : poll
	// callers give the latency window of the release category they set up
	task automatic ext(input logic [2:0] t, input int lo, input int hi);
		int n;
		ext_type <= t;
		ext_go <= 1'b1;
		@(posedge core_clk_i);
		ext_go <= 1'b0;
		@(posedge core_clk_i);
		for (n = 0; n < 60; n++) begin
			@(posedge core_clk_i);
			if (busy === 1'b0) break;
		end
		bound(n);
		// pins pass two sync flops and up to two decision edges before state settles
		repeat (IN_SYNC_STAGES + 2) @(posedge core_clk_i);
		`CHK(lat >= lo && lat <= hi, 1'b1)
	endtask : ext
	initial begin
		rst_i = 1'b1;
		ahb_q = '0;
		ext_go = 1'b0;
		ext_type = 3'h0;
		rsp_err = 1'b0;
		rdat = 64'h1357_9BDF;
		fail_count = 0;
		total_checks = 0;
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		`CHK({sys_o.ad_oe, sys_o.release_n, hrdata_o}, 34'h3_0000_0000)
		repeat (4) @(posedge core_clk_i);
		bus(1'b1, OFS_CTRL, 32'h4);
		bus(1'b0, OFS_STATUS, 32'h0);
		`CHK(r[STAT_ENDIAN_BIT], 1'b1)
		for (i = 0; i < 3; i++) begin
			bus(1'b1, OFS_CTRL, 32'(i));
			bus(1'b1, OFS_ADDR, wa[i]);
			bus(1'b1, OFS_CMD, {27'h0, sz[i], 2'b01});
			wstb();
			`CHK(s.ad, {32'h0, ea[i]})
			`CHK(s.cmd[7:5], CMD_TYPE_WRITE)
		end
		bus(1'b1, OFS_ADDR, 32'h200);
		for (i = 0; i < 2; i++) begin
			rsp_err <= i[0];
			bus(1'b1, OFS_CMD, {27'h0, SIZE_WORD, 2'b00});
			wstb();
			`CHK(s.release_n, 1'b0)
			poll(STAT_RDPEND_BIT, 1'b0);
			`CHK(r[STAT_ERR_BIT], i[0])
		end
		bus(1'b0, OFS_RDATA_LO, 32'h0);
		`CHK(r, 32'h1357_9BDF)
		bus(1'b1, OFS_STATUS, 32'h8);
		rdat <= 64'hA5;
		ext(CMD_TYPE_WRITE, RLS_MIN_PCYC, RLS_MAX_CAT2);
		bus(1'b0, OFS_IP, 32'h0);
		`CHK(r[7:0], 8'hA5)
		ext(CMD_TYPE_NULL, RLS_MIN_PCYC, RLS_MAX_CAT2);
		bus(1'b0, OFS_STATUS, 32'h0);
		`CHK(r[STAT_SLAVE_BIT], 1'b0)
		ext(CMD_TYPE_READ, RLS_MIN_PCYC, RLS_MAX_CAT2);
		bus(1'b0, OFS_STATUS, 32'h0);
		`CHK(r[STAT_ERR_BIT], 1'b1)
		// split read: an external write slips in before the read response
		rdat <= 64'h5A;
		bus(1'b1, OFS_CMD, {27'h0, SIZE_WORD, 2'b00});
		ext(CMD_TYPE_WRITE, 0, 0);
		poll(STAT_RDPEND_BIT, 1'b0);
		bus(1'b0, OFS_RDATA_LO, 32'h0);
		`CHK(r, 32'h0000_005A)
		bus(1'b0, OFS_IP, 32'h0);
		`CHK(r[7:0], 8'h5A)
		give_verdict();
	end
endmodule : system_bus_request_arbitration_test
